//--- rpm_debug_bit.sv
`timescale 1ns/10ps
`default_nettype none

// One bit slot of the single-wire debug link, started by the host's fall
module rpm_debug_bit (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic clkEn,
  input  wire logic enable,
  input  wire logic tick,
  input  wire logic pinIn,
  input  wire logic txArmed,
  input  wire logic txBit,
  output logic      pinOut,
  output logic      pinOe,
  output logic      rxValid,
  output logic      rxBit,
  output logic      txDone
);

  logic [rpm_pkg::DBG_TICK_W-1:0] tick_q;
  logic                           busy_q;
  logic                           isTx_q;
  logic                           zero_q;
  logic                           pinPrev_q;
  logic                           last;

  assign last = tick && (tick_q == 4'(rpm_pkg::DBG_BIT_TICKS - 1));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_q    <= '0;
      busy_q    <= 1'b0;
      isTx_q    <= 1'b0;
      zero_q    <= 1'b0;
      pinPrev_q <= 1'b1;
    end else if (clkEn) begin
      pinPrev_q <= pinIn;
      if (!enable) begin
        busy_q <= 1'b0;
        tick_q <= '0;
      end else if (!busy_q && pinPrev_q && !pinIn) begin
        busy_q <= 1'b1;
        tick_q <= '0;
        isTx_q <= txArmed;
        zero_q <= txArmed && !txBit;
      end else if (busy_q && tick) begin
        tick_q <= tick_q + 4'h1;
        if (last) begin
          busy_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxValid <= 1'b0;
      rxBit   <= 1'b0;
      txDone  <= 1'b0;
    end else if (clkEn) begin
      rxValid <= busy_q && last && !isTx_q;
      txDone  <= busy_q && last && isTx_q;
      if (busy_q && !isTx_q && tick &&
          tick_q == 4'(rpm_pkg::DBG_SAMPLE_TICK)) begin
        rxBit <= pinIn;
      end
    end
  end

  // Open drain with one driven high tick after a zero for a fast rise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut <= 1'b1;
      pinOe  <= 1'b0;
    end else if (clkEn) begin
      pinOut <= 1'b1;
      pinOe  <= 1'b0;
      if (enable && busy_q && zero_q) begin
        if (tick_q < 4'(rpm_pkg::DBG_LOW0_TICKS)) begin
          pinOut <= 1'b0;
          pinOe  <= 1'b1;
        end else if (tick_q == 4'(rpm_pkg::DBG_LOW0_TICKS)) begin
          pinOe  <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

//--- rpm_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module rpm_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic resetPinIn,
  input wire logic resetPinOut,
  input wire logic resetPinOe,
  input wire logic debugModeSelectPinIn,
  input wire logic debugModeSelectPinOut,
  input wire logic debugModeSelectPinOe,
  input wire logic chipReset,
  input wire logic backgroundMode,
  input wire logic cpuHalt,
  input wire logic fetchResetVector,
  input wire logic selfClockSelect,
  input wire logic irqPullupEn,
  input wire logic irqPulldownEn,
  input wire logic branchIfPinHigh,
  input wire logic branchIfPinLow
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [5:0] oeCnt_q;
  logic       armed_q;
  // Power-on drive overlaps rst_n, so only drives begun in run are timed
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      oeCnt_q <= 6'h00;
      armed_q <= 1'b0;
    end else begin
      oeCnt_q <= resetPinOe ? oeCnt_q + 6'h01 : 6'h00;
      armed_q <= $rose(resetPinOe) | (armed_q & resetPinOe);
    end
  end
  drive_len_a:
    assert property ($fell(resetPinOe) && armed_q |-> oeCnt_q == 6'h22)
    else $error("reset pin drive length wrong");
  drive_low_a:
    assert property (resetPinOe |-> !resetPinOut)
    else $error("reset pin driven high");
  sample_wait_a:
    assert property ($fell(resetPinOe) && resetPinIn
                     |-> ##35 chipReset ##[1:6] !chipReset)
    else $error("reset exit not after sample wait");
  pin_reset_a:
    assert property ($fell(resetPinIn) && !chipReset |-> ##[1:3] resetPinOe)
    else $error("pin low did not start reset");
  mode_pin_a:
    assert property (chipReset |-> !debugModeSelectPinOe)
    else $error("mode pin driven during reset");
  mode_pick_a:
    assert property ($fell(chipReset)
                     |-> backgroundMode == !debugModeSelectPinIn)
    else $error("mode not taken from pin");
  vector_fetch_a:
    assert property ($fell(chipReset) && debugModeSelectPinIn
                     |-> $past(fetchResetVector) && !fetchResetVector &&
                         !cpuHalt)
    else $error("reset vector pulse wrong");
  halt_bgnd_a:
    assert property (backgroundMode |-> cpuHalt)
    else $error("background mode without halt");
  speedup_short_a:
    assert property (debugModeSelectPinOe && debugModeSelectPinOut
                     |=> !debugModeSelectPinOe)
    else $error("speedup pulse too long");
  self_clock_a:
    assert property (chipReset |-> selfClockSelect)
    else $error("self clock not used in reset");
  pull_excl_a:
    assert property (irqPulldownEn |-> !irqPullupEn)
    else $error("pullup and pulldown together");
  branch_excl_a:
    assert property (!(branchIfPinHigh && branchIfPinLow))
    else $error("both branch levels true");
endmodule
bind rpm_reset_mode rpm_monitor mon_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .resetPinIn(resetPinIn),
  .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
  .debugModeSelectPinIn(debugModeSelectPinIn),
  .debugModeSelectPinOut(debugModeSelectPinOut),
  .debugModeSelectPinOe(debugModeSelectPinOe), .chipReset(chipReset),
  .backgroundMode(backgroundMode), .cpuHalt(cpuHalt),
  .fetchResetVector(fetchResetVector), .selfClockSelect(selfClockSelect),
  .irqPullupEn(irqPullupEn), .irqPulldownEn(irqPulldownEn),
  .branchIfPinHigh(branchIfPinHigh), .branchIfPinLow(branchIfPinLow));
`default_nettype wire

//--- rpm_partner.sv
`timescale 1ns/10ps
`default_nettype none
module rpm_partner (
  input  wire logic sys_clk,
  input  wire logic rstOe,
  input  wire logic rstOut,
  input  wire logic dbgOe,
  input  wire logic dbgOut,
  output logic      rstPin,
  output logic      dbgPin
);
  logic pressLow = 1'b0;
  logic podLow = 1'b0;
  // Both wires have pull-ups; on the reset wire whoever pulls low wins, on the debug wire the chip's drive wins over the pod
  assign rstPin = !(pressLow || (rstOe && !rstOut));
  assign dbgPin = dbgOe ? dbgOut : !podLow;
  task automatic press(input int n);
    pressLow <= 1'b1;
    repeat (n) @(posedge sys_clk);
    pressLow <= 1'b0;
  endtask
  // A one is low 4 ticks, a zero 13; slots padded past 16 ticks
  task automatic sendByte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      podLow <= 1'b1;
      repeat (b[i] ? 4 : 13) @(posedge sys_clk);
      podLow <= 1'b0;
      repeat (b[i] ? 16 : 7) @(posedge sys_clk);
    end
  endtask
  task automatic readByte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      podLow <= 1'b1;
      repeat (2) @(posedge sys_clk);
      podLow <= 1'b0;
      repeat (8) @(posedge sys_clk);
      b[i] = dbgPin;
      repeat (10) @(posedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire

//--- rpm_pkg.sv
package rpm_pkg;

  // Reset pin sequence, in bus clock cycles
  localparam int unsigned RST_DRIVE_CYCLES  = 34;
  localparam int unsigned RST_SAMPLE_CYCLES = 38;
  localparam int unsigned RST_CNT_W         = 6;

  // Debug serial link, in debug controller clock ticks
  localparam int unsigned DBG_BIT_TICKS   = 16;
  localparam int unsigned DBG_SAMPLE_TICK = 10;
  localparam int unsigned DBG_LOW0_TICKS  = 13;
  localparam int unsigned DBG_TICK_W      = 4;
  localparam int unsigned DBG_BYTE_BITS   = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_CAUSE  = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CLOCK  = 8'h08;
  localparam logic [7:0] OFS_IRQ    = 8'h0C;
  localparam logic [7:0] OFS_DBGCTL = 8'h10;
  localparam logic [7:0] OFS_DBGDAT = 8'h14;

  // Reset cause bit positions
  localparam int unsigned CAUSE_PIN     = 0;
  localparam int unsigned CAUSE_POR     = 1;
  localparam int unsigned CAUSE_LVD     = 2;
  localparam int unsigned CAUSE_COP     = 3;
  localparam int unsigned CAUSE_ILOP    = 4;
  localparam int unsigned CAUSE_ILAD    = 5;
  localparam int unsigned CAUSE_DBG     = 6;
  localparam int unsigned CAUSE_W       = 7;
  localparam logic [6:0]  CAUSE_RESET   = 7'h01 << CAUSE_POR;
  localparam logic [6:0]  CAUSE_INTMASK = 7'h7E;

  // Status bit positions
  localparam int unsigned ST_BGND    = 0;
  localparam int unsigned ST_HALT    = 1;
  localparam int unsigned ST_SAMPLE  = 2;
  localparam int unsigned ST_IRQPIN  = 3;
  localparam int unsigned ST_RXFULL  = 4;
  localparam int unsigned ST_TXBUSY  = 5;

  // Clock control fields
  localparam int unsigned CLK_RANGE   = 0;
  localparam int unsigned CLK_STOPREC = 1;
  localparam int unsigned CLK_EXTSRC  = 2;
  localparam logic [2:0]  CLK_RESET   = 3'h0;

  // External interrupt control fields
  localparam int unsigned IRQ_EN    = 0;
  localparam int unsigned IRQ_RISE  = 1;
  localparam int unsigned IRQ_LEVEL = 2;
  localparam int unsigned IRQ_FLAG  = 3;
  localparam logic [2:0]  IRQ_RESET = 3'h0;

  // Debug control fields
  localparam int unsigned DC_RESUME = 0;
  localparam int unsigned DC_FORCE  = 1;

  typedef enum logic [1:0] {
    SEQ_DRIVE = 2'b00,
    SEQ_WAIT  = 2'b01,
    SEQ_HOLD  = 2'b10,
    SEQ_RUN   = 2'b11
  } rpm_seq_t;

endpackage

//--- rpm_reset_mode.sv
`timescale 1ns/10ps
`default_nettype none

module rpm_reset_mode (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        resetPinIn,
  output logic             resetPinOut,
  output logic             resetPinOe,
  input  wire logic        debugModeSelectPinIn,
  output logic             debugModeSelectPinOut,
  output logic             debugModeSelectPinOe,
  input  wire logic        debugClkEn,
  input  wire logic        lvdReset,
  input  wire logic        copReset,
  input  wire logic        illegalOpReset,
  input  wire logic        illegalAddrReset,
  output logic             chipReset,
  output logic             backgroundMode,
  output logic             cpuHalt,
  output logic             fetchResetVector,
  output logic             selfClockSelect,
  output logic             oscRangeHigh,
  output logic             stopRecoverySelfClock,
  input  wire logic        irqPinIn,
  output logic             irqPullupEn,
  output logic             irqPulldownEn,
  output logic             irqRequest,
  output logic             branchIfPinHigh,
  output logic             branchIfPinLow
);

  function automatic logic [2:0] regIndex(input logic [31:0] a);
    if (a[7:0] == rpm_pkg::OFS_CAUSE) begin
      regIndex = 3'h1;
    end else if (a[7:0] == rpm_pkg::OFS_STATUS) begin
      regIndex = 3'h2;
    end else if (a[7:0] == rpm_pkg::OFS_CLOCK) begin
      regIndex = 3'h3;
    end else if (a[7:0] == rpm_pkg::OFS_IRQ) begin
      regIndex = 3'h4;
    end else if (a[7:0] == rpm_pkg::OFS_DBGCTL) begin
      regIndex = 3'h5;
    end else if (a[7:0] == rpm_pkg::OFS_DBGDAT) begin
      regIndex = 3'h6;
    end else begin
      regIndex = 3'h0;
    end
  endfunction

  rpm_pkg::rpm_seq_t                    seq_q;
  logic [rpm_pkg::RST_CNT_W-1:0]        cnt_q;
  logic [rpm_pkg::CAUSE_W-1:0]          cause_q;
  logic                                 pinSample_q;
  logic [2:0]                           clkCtl_q;
  logic [2:0]                           irqCtl_q;
  logic                                 irqPinPrev_q;
  logic                                 wrPend_q;
  logic [2:0]                           wrIdx_q;
  logic                                 rdPend_q;
  logic [2:0]                           rdIdx_q;
  logic [rpm_pkg::DBG_BYTE_BITS-1:0]    rxShift_q;
  logic [rpm_pkg::DBG_BYTE_BITS-1:0]    rxData_q;
  logic [2:0]                           rxCnt_q;
  logic                                 rxFull_q;
  logic [rpm_pkg::DBG_BYTE_BITS-1:0]    txShift_q;
  logic [2:0]                           txCnt_q;
  logic                                 txBusy_q;
  logic                                 addrPhase;
  logic                                 wrDone;
  logic [rpm_pkg::CAUSE_W-1:0]          intCause;
  logic                                 intReq;
  logic                                 forceReset;
  logic                                 resumeCpu;
  logic                                 irqEdge;
  logic                                 irqAck;
  logic                                 dbgRxValid;
  logic                                 dbgRxBit;
  logic                                 dbgTxDone;
  logic                                 dbgEnable;

  assign addrPhase = hsel && htrans[1] && hready;
  assign wrDone    = clkEn && wrPend_q;
  assign forceReset = wrDone && wrIdx_q == 3'h5 && hwdata[rpm_pkg::DC_FORCE];
  assign resumeCpu  = wrDone && wrIdx_q == 3'h5 && hwdata[rpm_pkg::DC_RESUME];
  assign irqAck     = wrDone && wrIdx_q == 3'h4 && hwdata[rpm_pkg::IRQ_FLAG];
  assign dbgEnable  = (seq_q == rpm_pkg::SEQ_RUN);

  // Internal reset sources as cause bits
  always_comb begin
    intCause = '0;
    intCause[rpm_pkg::CAUSE_LVD]  = lvdReset;
    intCause[rpm_pkg::CAUSE_COP]  = copReset;
    intCause[rpm_pkg::CAUSE_ILOP] = illegalOpReset;
    intCause[rpm_pkg::CAUSE_ILAD] = illegalAddrReset;
    intCause[rpm_pkg::CAUSE_DBG]  = forceReset;
    intReq = |intCause;
  end

  // Reset pin sequencer; sources arriving mid-sequence are absorbed
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_q       <= rpm_pkg::SEQ_DRIVE;
      cnt_q       <= '0;
      pinSample_q <= 1'b1;
    end else if (clkEn) begin
      case (seq_q)
        rpm_pkg::SEQ_DRIVE: begin
          if (cnt_q == 6'(rpm_pkg::RST_DRIVE_CYCLES - 1)) begin
            seq_q <= rpm_pkg::SEQ_WAIT;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 6'h01;
          end
        end
        rpm_pkg::SEQ_WAIT: begin
          if (cnt_q == 6'(rpm_pkg::RST_SAMPLE_CYCLES - 1)) begin
            pinSample_q <= resetPinIn;
            cnt_q       <= '0;
            seq_q <= resetPinIn ? rpm_pkg::SEQ_RUN : rpm_pkg::SEQ_HOLD;
          end else begin
            cnt_q <= cnt_q + 6'h01;
          end
        end
        rpm_pkg::SEQ_HOLD: begin
          if (resetPinIn) begin
            seq_q <= rpm_pkg::SEQ_RUN;
          end
        end
        rpm_pkg::SEQ_RUN: begin
          if (intReq || !resetPinIn) begin
            seq_q <= rpm_pkg::SEQ_DRIVE;
            cnt_q <= '0;
          end
        end
        default: begin
          seq_q <= rpm_pkg::SEQ_DRIVE;
        end
      endcase
    end
  end

  // Pin driver and chip reset follow the sequencer one cycle later
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      resetPinOut <= 1'b0;
      resetPinOe  <= 1'b1;
      chipReset   <= 1'b1;
    end else if (clkEn) begin
      resetPinOut <= 1'b0;
      resetPinOe  <= (seq_q == rpm_pkg::SEQ_DRIVE);
      chipReset   <= (seq_q != rpm_pkg::SEQ_RUN);
    end
  end

  // Cause is replaced on each new reset; software clears by writing ones
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_q <= rpm_pkg::CAUSE_RESET;
    end else if (clkEn) begin
      if (seq_q == rpm_pkg::SEQ_RUN && (intReq || !resetPinIn)) begin
        cause_q <= intCause;
        cause_q[rpm_pkg::CAUSE_PIN] <= !intReq;
      end else if (seq_q == rpm_pkg::SEQ_WAIT && !resetPinIn &&
                   cnt_q == 6'(rpm_pkg::RST_SAMPLE_CYCLES - 1) &&
                   |(cause_q & rpm_pkg::CAUSE_INTMASK)) begin
        cause_q[rpm_pkg::CAUSE_PIN] <= 1'b1;
      end else if (wrDone && wrIdx_q == 3'h1) begin
        cause_q <= cause_q & ~hwdata[rpm_pkg::CAUSE_W-1:0];
      end
    end
  end

  // Mode pin is sampled as the chip leaves reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      backgroundMode   <= 1'b0;
      cpuHalt          <= 1'b1;
      fetchResetVector <= 1'b0;
    end else if (clkEn) begin
      fetchResetVector <= 1'b0;
      if (seq_q != rpm_pkg::SEQ_RUN) begin
        cpuHalt <= 1'b1;
        if ((seq_q == rpm_pkg::SEQ_HOLD && resetPinIn) ||
            (seq_q == rpm_pkg::SEQ_WAIT && resetPinIn &&
             cnt_q == 6'(rpm_pkg::RST_SAMPLE_CYCLES - 1))) begin
          backgroundMode   <= !debugModeSelectPinIn;
          cpuHalt          <= !debugModeSelectPinIn;
          fetchResetVector <= debugModeSelectPinIn;
        end
      end else if (resumeCpu) begin
        backgroundMode <= 1'b0;
        cpuHalt        <= 1'b0;
      end
    end
  end

  // Clock control; reset value selects the self-clocked source
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkCtl_q <= rpm_pkg::CLK_RESET;
    end else if (clkEn && wrDone && wrIdx_q == 3'h3) begin
      clkCtl_q <= hwdata[2:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      selfClockSelect       <= 1'b1;
      oscRangeHigh          <= 1'b0;
      stopRecoverySelfClock <= 1'b0;
    end else if (clkEn) begin
      selfClockSelect <= (seq_q != rpm_pkg::SEQ_RUN) ||
                         !clkCtl_q[rpm_pkg::CLK_EXTSRC];
      oscRangeHigh    <= clkCtl_q[rpm_pkg::CLK_RANGE];
      stopRecoverySelfClock <= clkCtl_q[rpm_pkg::CLK_STOPREC];
    end
  end

  // External interrupt pin
  assign irqEdge = irqCtl_q[rpm_pkg::IRQ_RISE] ?
                   (irqPinIn && !irqPinPrev_q) :
                   (!irqPinIn && irqPinPrev_q);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqCtl_q     <= rpm_pkg::IRQ_RESET;
      irqPinPrev_q <= 1'b1;
    end else if (clkEn) begin
      irqPinPrev_q <= irqPinIn;
      if (wrDone && wrIdx_q == 3'h4) begin
        irqCtl_q <= hwdata[2:0];
      end
    end
  end

  // Set wins over acknowledge; level mode tracks the active level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqRequest      <= 1'b0;
      irqPullupEn     <= 1'b0;
      irqPulldownEn   <= 1'b0;
      branchIfPinHigh <= 1'b0;
      branchIfPinLow  <= 1'b0;
    end else if (clkEn) begin
      if (!irqCtl_q[rpm_pkg::IRQ_EN]) begin
        irqRequest <= 1'b0;
      end else if (irqEdge) begin
        irqRequest <= 1'b1;
      end else if (irqCtl_q[rpm_pkg::IRQ_LEVEL]) begin
        irqRequest <= (irqPinIn == irqCtl_q[rpm_pkg::IRQ_RISE]);
      end else if (irqAck) begin
        irqRequest <= 1'b0;
      end
      irqPulldownEn <= irqCtl_q[rpm_pkg::IRQ_EN] &&
                       irqCtl_q[rpm_pkg::IRQ_RISE];
      irqPullupEn   <= irqCtl_q[rpm_pkg::IRQ_EN] &&
                       !irqCtl_q[rpm_pkg::IRQ_RISE];
      branchIfPinHigh <= irqCtl_q[rpm_pkg::IRQ_EN] && irqPinIn;
      branchIfPinLow  <= irqCtl_q[rpm_pkg::IRQ_EN] && !irqPinIn;
    end
  end

  // Debug link: debugClkEn may be held high for bus-rate bit timing
  rpm_debug_bit u_bit (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .enable  (dbgEnable),
    .tick    (debugClkEn),
    .pinIn   (debugModeSelectPinIn),
    .txArmed (txBusy_q),
    .txBit   (txShift_q[rpm_pkg::DBG_BYTE_BITS-1]),
    .pinOut  (debugModeSelectPinOut),
    .pinOe   (debugModeSelectPinOe),
    .rxValid (dbgRxValid),
    .rxBit   (dbgRxBit),
    .txDone  (dbgTxDone)
  );

  // Bits pair MSB first into bytes; a byte read clears the full flag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxShift_q <= '0;
      rxData_q  <= '0;
      rxCnt_q   <= '0;
      rxFull_q  <= 1'b0;
    end else if (clkEn) begin
      if (!dbgEnable) begin
        rxCnt_q <= '0;
      end else if (dbgRxValid) begin
        rxShift_q <= {rxShift_q[6:0], dbgRxBit};
        rxCnt_q   <= rxCnt_q + 3'h1;
        if (rxCnt_q == 3'h7) begin
          rxData_q <= {rxShift_q[6:0], dbgRxBit};
          rxFull_q <= 1'b1;
        end
      end
      if (rdPend_q && rdIdx_q == 3'h6 &&
          !(dbgRxValid && rxCnt_q == 3'h7)) begin
        rxFull_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txShift_q <= '0;
      txCnt_q   <= '0;
      txBusy_q  <= 1'b0;
    end else if (clkEn) begin
      if (!dbgEnable) begin
        txBusy_q <= 1'b0;
      end else if (wrDone && wrIdx_q == 3'h6 && !txBusy_q) begin
        txShift_q <= hwdata[7:0];
        txCnt_q   <= '0;
        txBusy_q  <= 1'b1;
      end else if (dbgTxDone) begin
        txShift_q <= {txShift_q[6:0], 1'b0};
        txCnt_q   <= txCnt_q + 3'h1;
        if (txCnt_q == 3'h7) begin
          txBusy_q <= 1'b0;
        end
      end
    end
  end

  // Bus slave: no wait states, read data prepared in the address phase
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_q  <= 1'b0;
      wrIdx_q   <= '0;
      rdPend_q  <= 1'b0;
      rdIdx_q   <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (clkEn) begin
      wrPend_q <= addrPhase && hwrite;
      rdPend_q <= addrPhase && !hwrite;
      wrIdx_q  <= regIndex(haddr);
      rdIdx_q  <= regIndex(haddr);
      if (addrPhase && !hwrite) begin
        hrdata <= '0;
        case (regIndex(haddr))
          3'h1: hrdata[rpm_pkg::CAUSE_W-1:0] <= cause_q;
          3'h2: begin
            hrdata[rpm_pkg::ST_BGND]   <= backgroundMode;
            hrdata[rpm_pkg::ST_HALT]   <= cpuHalt;
            hrdata[rpm_pkg::ST_SAMPLE] <= pinSample_q;
            hrdata[rpm_pkg::ST_IRQPIN] <= irqPinIn;
            hrdata[rpm_pkg::ST_RXFULL] <= rxFull_q;
            hrdata[rpm_pkg::ST_TXBUSY] <= txBusy_q;
          end
          3'h3: hrdata[2:0] <= clkCtl_q;
          3'h4: hrdata[3:0] <= {irqRequest, irqCtl_q};
          3'h6: hrdata[7:0] <= rxData_q;
          default: hrdata <= '0;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

//--- tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        sys_clk = 1'b0;
  logic        rst_n, hsel, hwrite, hreadyout, irqPin;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  req;
  logic [7:0]  b;
  logic        rstOe, rstOut, rstPin, dbgOe, dbgOut, dbgPin;
  logic        chipReset, backgroundMode, cpuHalt, selfClockSelect;
  logic        oscRangeHigh, stopRecoverySelfClock, irqRequest;
  logic        irqPullupEn, irqPulldownEn, branchIfPinHigh, branchIfPinLow;
  int          n_mismatch = 0;
  int          checks_done = 0;
  logic [31:0] seed = 32'h0000_006C;
  always #5 sys_clk = ~sys_clk;
  rpm_reset_mode dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(), .resetPinIn(rstPin),
    .resetPinOut(rstOut), .resetPinOe(rstOe),
    .debugModeSelectPinIn(dbgPin), .debugModeSelectPinOut(dbgOut),
    .debugModeSelectPinOe(dbgOe), .debugClkEn(1'b1),
    .lvdReset(req[0]), .copReset(req[1]), .illegalOpReset(req[2]),
    .illegalAddrReset(req[3]), .chipReset(chipReset),
    .backgroundMode(backgroundMode), .cpuHalt(cpuHalt),
    .fetchResetVector(), .selfClockSelect(selfClockSelect),
    .oscRangeHigh(oscRangeHigh),
    .stopRecoverySelfClock(stopRecoverySelfClock), .irqPinIn(irqPin),
    .irqPullupEn(irqPullupEn), .irqPulldownEn(irqPulldownEn),
    .irqRequest(irqRequest), .branchIfPinHigh(branchIfPinHigh),
    .branchIfPinLow(branchIfPinLow));
  rpm_partner pod_u (
    .sys_clk(sys_clk), .rstOe(rstOe), .rstOut(rstOut), .dbgOe(dbgOe),
    .dbgOut(dbgOut), .rstPin(rstPin), .dbgPin(dbgPin));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask
  // Waits through a reset sequence that has just been started
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    while (chipReset !== 1'b0) @(posedge sys_clk);
    @(posedge sys_clk);
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata, req, irqPin} = '0;
    hsize = 3'h2;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    settle();
    rdc(rpm_pkg::OFS_CAUSE, 32'(rpm_pkg::CAUSE_RESET));
    rdc(rpm_pkg::OFS_CLOCK, 32'(rpm_pkg::CLK_RESET));
    chk({selfClockSelect, backgroundMode}, 2'b10);
    for (int i = 0; i < 4; i++) begin
      req <= 4'h1 << i;
      @(posedge sys_clk);
      req <= 4'h0;
      settle();
      rdc(rpm_pkg::OFS_CAUSE, 32'h1 << (rpm_pkg::CAUSE_LVD + i));
      rdc(rpm_pkg::OFS_STATUS, 32'h0000_0004);
    end
    pod_u.press(5);
    settle();
    rdc(rpm_pkg::OFS_CAUSE, 32'h0000_0001);
    req <= 4'h1;
    pod_u.pressLow <= 1'b1;
    @(posedge sys_clk);
    req <= 4'h0;
    repeat (100) @(posedge sys_clk);
    pod_u.pressLow <= 1'b0;
    settle();
    rdc(rpm_pkg::OFS_CAUSE, 32'h0000_0005);
    repeat (4) begin
      r = xs() & 32'h0000_0007;
      wr(rpm_pkg::OFS_CLOCK, r);
      rdc(rpm_pkg::OFS_CLOCK, r);
      chk({stopRecoverySelfClock, oscRangeHigh}, r[1:0]);
      chk(selfClockSelect, !r[2]);
    end
    wr(rpm_pkg::OFS_IRQ, 32'h0000_0000);
    repeat (3) begin
      irqPin <= ~irqPin;
      repeat (3) @(posedge sys_clk);
    end
    chk({irqRequest, branchIfPinHigh, branchIfPinLow}, 3'b000);
    rdc(rpm_pkg::OFS_IRQ, 32'h0000_0000);
    irqPin <= 1'b0;
    wr(rpm_pkg::OFS_IRQ, 32'h0000_0003);
    repeat (4) @(posedge sys_clk);
    chk({irqPulldownEn, irqPullupEn, branchIfPinLow, irqRequest}, 4'hA);
    irqPin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk({irqRequest, branchIfPinHigh}, 2'b11);
    rdc(rpm_pkg::OFS_IRQ, 32'h0000_000B);
    wr(rpm_pkg::OFS_IRQ, 32'h0000_000B);
    wr(rpm_pkg::OFS_IRQ, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    chk({irqRequest, irqPulldownEn, irqPullupEn}, 3'b001);
    wr(rpm_pkg::OFS_IRQ, 32'h0000_0005);
    irqPin <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(irqRequest, 1'b1);
    irqPin <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(irqRequest, 1'b0);
    irqPin <= 1'b0;
    pod_u.podLow <= 1'b1;
    wr(rpm_pkg::OFS_DBGCTL, 32'h0000_0002);
    settle();
    chk({backgroundMode, cpuHalt}, 2'b11);
    pod_u.podLow <= 1'b0;
    rdc(rpm_pkg::OFS_CAUSE, 32'h1 << rpm_pkg::CAUSE_DBG);
    pod_u.sendByte(8'hA5);
    rdc(rpm_pkg::OFS_STATUS, 32'h0000_0017);
    rdc(rpm_pkg::OFS_DBGDAT, 32'h0000_00A5);
    wr(rpm_pkg::OFS_DBGDAT, 32'h0000_005A);
    pod_u.readByte(b);
    chk(b, 8'h5A);
    wr(rpm_pkg::OFS_DBGCTL, 32'h0000_0001);
    @(posedge sys_clk);
    chk({backgroundMode, cpuHalt}, 2'b00);
    rdc(8'h1C, 32'h0000_0000);
    final_report();
  end
endmodule
`default_nettype wire
